// >>> rtl/keyed_watchdog_timer.sv
// Summary of operation
// - after any reset the watchdog runs: enabled, resets, longest timeout
// - one unlock admits at most one configuration write
// - while enabled a counter advances; passing the duration is timeout
// - AAAAh then 5555h clears the counter; software must service
// - bit 15 set enables counting, cleared disables it
// - bit 14 set: timeout asserts a full system reset
// - bit 14 clear: timeout raises NMI, or system reset if flag set
// - bit 13 set by watchdog reset, survives it, cleared by key or NRST
// - bit 12 set after NMI, cleared by any key sequence
// - bits 7:0 pick exponent 10 or 20..26; duration 2^exp clocks
`timescale 1ns/100ps
`include "wdt_map.svh"

module keyed_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int EXP_LOW  = `WDT_EXP_LOW,
    parameter int EXP_BASE = `WDT_EXP_BASE
) (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    // axi4-lite write address
    input  wire logic [11:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output wire logic        S_AXI_AWREADY,
    // axi4-lite write data
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output wire logic        S_AXI_WREADY,
    // axi4-lite write response
    output wire logic [1:0]  S_AXI_BRESP,
    output wire logic        S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // axi4-lite read address
    input  wire logic [11:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output wire logic        S_AXI_ARREADY,
    // axi4-lite read data
    output wire logic [31:0] S_AXI_RDATA,
    output wire logic [1:0]  S_AXI_RRESP,
    output wire logic        S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // watchdog actions
    output wire logic        WDT_SYS_RESET,
    output wire logic        WDT_NMI,
    output wire logic        IRQ
);

    localparam int CNT_W = 27;

    logic             aw_held_reg;
    logic [11:0]      aw_addr_reg;
    logic             w_held_reg;
    logic [31:0]      w_data_reg;
    logic [3:0]       w_strb_reg;
    logic             bvalid_reg;
    logic [1:0]       bresp_reg;
    logic             rvalid_reg;
    logic [31:0]      rdata_reg;
    logic [1:0]       rresp_reg;
    ctrl_t            ctrl_reg;
    ctrl_t            ctrl_next;
    ctrl_t            wr_fields;
    logic             unlocked_reg;
    logic             unlocked_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [1:0]       stat_reg;
    logic [1:0]       stat_next;
    logic [1:0]       mask_reg;
    logic             sysrst_reg;
    logic             nmi_reg;
    key_evt_t         key_evt;
    logic [4:0]       exp_sel;
    logic             sel_valid;

    // bus slave decode
    wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_take  = S_AXI_WVALID && S_AXI_WREADY;
    wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
    wire wr_do   = aw_held_reg && w_held_reg;
    wire hit_ctrl_w = aw_addr_reg == `WDT_CTRL_ADDR;
    wire hit_stat_w = aw_addr_reg == `WDT_STAT_ADDR;
    wire hit_mask_w = aw_addr_reg == `WDT_MASK_ADDR;
    wire wr_mapped  = hit_ctrl_w || hit_stat_w || hit_mask_w;
    // control needs both low lanes; a half word would split a key
    wire wr_ctrl = wr_do && hit_ctrl_w && (&w_strb_reg[1:0]);
    wire wr_stat = wr_do && hit_stat_w && w_strb_reg[0];
    wire wr_mask = wr_do && hit_mask_w && w_strb_reg[0];
    wire hit_ctrl_r = S_AXI_ARADDR == `WDT_CTRL_ADDR;
    wire hit_stat_r = S_AXI_ARADDR == `WDT_STAT_ADDR;
    wire hit_mask_r = S_AXI_ARADDR == `WDT_MASK_ADDR;
    wire rd_mapped  = hit_ctrl_r || hit_stat_r || hit_mask_r;
    wire [31:0] rd_mux = hit_ctrl_r ? {16'h0000, ctrl_reg} :
                         hit_stat_r ? {30'h00000000, stat_reg} :
                         hit_mask_r ? {30'h00000000, mask_reg} :
                         32'h00000000;

    assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
    assign S_AXI_WREADY  = !w_held_reg && !bvalid_reg;
    assign S_AXI_BVALID  = bvalid_reg;
    assign S_AXI_BRESP   = bresp_reg;
    assign S_AXI_ARREADY = !rvalid_reg;
    assign S_AXI_RVALID  = rvalid_reg;
    assign S_AXI_RDATA   = rdata_reg;
    assign S_AXI_RRESP   = rresp_reg;

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_held_reg  <= 1'b0;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `AXI_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR;
            end else if (wr_do) begin
                aw_held_reg <= 1'b0;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end else if (wr_do) begin
                w_held_reg <= 1'b0;
            end
            if (wr_do) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_mapped ? `AXI_OKAY : `AXI_SLVERR;
            end else if (S_AXI_BREADY) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= `AXI_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= rd_mapped ? `AXI_OKAY : `AXI_SLVERR;
        end else if (S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end

    key_seq_detect u_keys (
        .SYS_CLK   (SYS_CLK),
        .NRST      (NRST),
        .WR_STROBE (wr_ctrl),
        .WR_DATA   (w_data_reg[15:0]),
        .EVT       (key_evt)
    );

    // lowest set select bit; all zero never times out
    always_comb begin
        exp_sel   = 5'(EXP_BASE + 6);
        sel_valid = 1'b0;
        for (int i = 7; i >= 1; i--) begin
            if (ctrl_reg.timeout_sel[i]) begin
                exp_sel   = 5'(EXP_BASE + i - 1);
                sel_valid = 1'b1;
            end
        end
        if (ctrl_reg.timeout_sel[0]) begin
            exp_sel   = 5'(EXP_LOW);
            sel_valid = 1'b1;
        end
    end

    wire [CNT_W-1:0] dur_m1 = (CNT_W'(1) << exp_sel) - CNT_W'(1);
    wire running  = ctrl_reg.watchdog_run_enable;
    // a shortened setting below the running count times out at once
    wire timeout  = running && sel_valid && count_reg >= dur_m1;
    wire rst_fire = timeout && (ctrl_reg.timeout_action_select
                                || ctrl_reg.interrupt_raised_flag);
    wire nmi_fire = timeout && !rst_fire;

    always_comb begin
        count_next = count_reg;
        if (timeout || key_evt.service) begin
            count_next = '0;
        end else if (running) begin
            count_next = count_reg + CNT_W'(1);
        end
    end

    // flags and reserved bits are never loaded from a write
    assign wr_fields = ctrl_t'(w_data_reg[15:0]);

    always_comb begin
        ctrl_next = ctrl_reg;
        if (unlocked_reg && key_evt.cfg_write) begin
            ctrl_next.watchdog_run_enable   = wr_fields.watchdog_run_enable;
            ctrl_next.timeout_action_select = wr_fields.timeout_action_select;
            ctrl_next.timeout_sel           = wr_fields.timeout_sel;
        end
        if (key_evt.any_key) begin
            ctrl_next.watchdog_reset_seen_flag = 1'b0;
            ctrl_next.interrupt_raised_flag    = 1'b0;
        end
        if (nmi_fire) begin
            ctrl_next.interrupt_raised_flag = 1'b1;
        end
        if (rst_fire) begin
            ctrl_next = ctrl_t'(`WDT_CTRL_RESET);
            ctrl_next.watchdog_reset_seen_flag = 1'b1;
        end
    end

    // any control write spends the unlock, key words included
    always_comb begin
        unlocked_next = unlocked_reg;
        if (rst_fire) begin
            unlocked_next = 1'b0;
        end else if (key_evt.unlock) begin
            unlocked_next = 1'b1;
        end else if (wr_ctrl) begin
            unlocked_next = 1'b0;
        end
    end

    // set wins over a same-cycle write-one clear
    assign stat_next = (stat_reg & ~(wr_stat ? w_data_reg[1:0] : 2'b00))
                       | {rst_fire, nmi_fire};

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ctrl_reg     <= ctrl_t'(`WDT_CTRL_RESET);
            unlocked_reg <= 1'b0;
            count_reg    <= '0;
            stat_reg     <= 2'b00;
            mask_reg     <= 2'b00;
            sysrst_reg   <= 1'b0;
            nmi_reg      <= 1'b0;
        end else begin
            ctrl_reg     <= ctrl_next;
            unlocked_reg <= unlocked_next;
            count_reg    <= count_next;
            stat_reg     <= stat_next;
            if (wr_mask) begin
                mask_reg <= w_data_reg[1:0];
            end
            sysrst_reg   <= rst_fire;
            nmi_reg      <= nmi_fire;
        end
    end

    assign WDT_SYS_RESET = sysrst_reg;
    assign WDT_NMI       = nmi_reg;
    assign IRQ           = |(stat_reg & mask_reg);

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    property p_reset_state;
        $rose(NRST) |-> ctrl_reg == ctrl_t'(`WDT_CTRL_RESET)
                        && count_reg == '0;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("control not at reset value after reset");

    property p_locked_ignore;
        key_evt.cfg_write && !unlocked_reg && !timeout
            |=> $stable(ctrl_reg.timeout_sel)
                && $stable(ctrl_reg.watchdog_run_enable);
    endproperty
    a_locked_ignore: assert property (p_locked_ignore)
        else $error("locked configuration write changed control");

    property p_single_write;
        unlocked_reg && key_evt.cfg_write |=> !unlocked_reg;
    endproperty
    a_single_write: assert property (p_single_write)
        else $error("unlock survived a configuration write");

    property p_service_clears;
        key_evt.service |=> count_reg == '0 ##1
            count_reg == (running ? CNT_W'(1) : '0);
    endproperty
    a_service_clears: assert property (p_service_clears)
        else $error("service key did not restart the count");

    property p_disabled_holds;
        !running && !key_evt.service |=> $stable(count_reg);
    endproperty
    a_disabled_holds: assert property (p_disabled_holds)
        else $error("counter moved while disabled");

    property p_reset_action;
        timeout && ctrl_reg.timeout_action_select
            |=> WDT_SYS_RESET && !WDT_NMI
                && ctrl_reg.watchdog_reset_seen_flag;
    endproperty
    a_reset_action: assert property (p_reset_action)
        else $error("timeout did not raise system reset");

    property p_nmi_action;
        timeout && !ctrl_reg.timeout_action_select
            && !ctrl_reg.interrupt_raised_flag
            |=> WDT_NMI && !WDT_SYS_RESET && ctrl_reg.interrupt_raised_flag;
    endproperty
    a_nmi_action: assert property (p_nmi_action)
        else $error("timeout did not raise nmi");

    property p_key_clears_flags;
        key_evt.any_key && !timeout
            |=> !ctrl_reg.watchdog_reset_seen_flag
                && !ctrl_reg.interrupt_raised_flag;
    endproperty
    a_key_clears_flags: assert property (p_key_clears_flags)
        else $error("key sequence left a flag set");

    property p_count_bound;
        running && sel_valid && $stable(ctrl_reg) |-> count_reg <= dur_m1;
    endproperty
    a_count_bound: assert property (p_count_bound)
        else $error("count passed the selected duration");

    c_nmi: cover property (nmi_fire);
    c_sysreset: cover property (rst_fire);
    c_unlock_cfg: cover property (unlocked_reg && key_evt.cfg_write);
    c_nmi_then_reset: cover property (WDT_NMI ##[1:1000] WDT_SYS_RESET);

endmodule

// >>> rtl/wdt_map.svh
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// register indexes; byte address is four times the index
`define WDT_CTRL_IDX    10'h0E6
`define WDT_STAT_IDX    10'h0E8
`define WDT_MASK_IDX    10'h0EA
`define WDT_CTRL_ADDR   {`WDT_CTRL_IDX, 2'b00}
`define WDT_STAT_ADDR   {`WDT_STAT_IDX, 2'b00}
`define WDT_MASK_ADDR   {`WDT_MASK_IDX, 2'b00}

`define WDT_CTRL_RESET  16'hC080
`define WDT_EXP_LOW     10
`define WDT_EXP_BASE    20

// key words
`define WDT_KEY_UNLOCK1 16'h3333
`define WDT_KEY_UNLOCK2 16'hCCCC
`define WDT_KEY_SERVE1  16'hAAAA
`define WDT_KEY_SERVE2  16'h5555

// interrupt status bits
`define WDT_EV_NMI      0
`define WDT_EV_RST      1

`define AXI_OKAY        2'h0
`define AXI_SLVERR      2'h2

`endif

// >>> rtl/wdt_pkg.sv
package wdt_pkg;

    typedef struct packed {
        logic       watchdog_run_enable;
        logic       timeout_action_select;
        logic       watchdog_reset_seen_flag;
        logic       interrupt_raised_flag;
        logic [3:0] reserved;
        logic [7:0] timeout_sel;
    } ctrl_t;

    typedef struct packed {
        logic unlock;
        logic service;
        logic any_key;
        logic cfg_write;
    } key_evt_t;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_GOT_UNLOCK1,
        KEY_GOT_SERVE1
    } key_state_t;

endpackage

// >>> rtl/key_seq_detect.sv
`timescale 1ns/100ps
`include "wdt_map.svh"

module key_seq_detect
    import wdt_pkg::*;
(
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    // control register writes
    input  wire logic        WR_STROBE,
    input  wire logic [15:0] WR_DATA,
    // classified write
    output key_evt_t         EVT
);

    key_state_t state_reg;
    key_state_t state_next;

    wire is_u1 = WR_DATA == `WDT_KEY_UNLOCK1;
    wire is_u2 = WR_DATA == `WDT_KEY_UNLOCK2;
    wire is_s1 = WR_DATA == `WDT_KEY_SERVE1;
    wire is_s2 = WR_DATA == `WDT_KEY_SERVE2;
    wire unlock_done = WR_STROBE && state_reg == KEY_GOT_UNLOCK1 && is_u2;
    wire serve_done  = WR_STROBE && state_reg == KEY_GOT_SERVE1 && is_s2;

    // first key words and completing words are never configuration
    wire cfg_done = WR_STROBE && !unlock_done && !serve_done
                    && !is_u1 && !is_s1;

    // one driver for the whole event word
    assign EVT = '{unlock:    unlock_done,
                   service:   serve_done,
                   any_key:   unlock_done || serve_done,
                   cfg_write: cfg_done};

    always_comb begin
        state_next = state_reg;
        if (WR_STROBE) begin
            if (is_u1) begin
                state_next = KEY_GOT_UNLOCK1;
            end else if (is_s1) begin
                state_next = KEY_GOT_SERVE1;
            end else begin
                state_next = KEY_IDLE;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            state_reg <= KEY_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    property p_key_discard;
        WR_STROBE && state_reg != KEY_IDLE && !is_u1 && !is_s1
            |=> state_reg == KEY_IDLE;
    endproperty
    a_key_discard: assert property (p_key_discard)
        else $error("key detector kept a broken sequence");

endmodule

// >>> tb/keyed_watchdog_timer_tb.sv
`timescale 1ns/100ps
`include "wdt_map.svh"

module keyed_watchdog_timer_tb;
    // short exponents keep the long timeouts affordable in simulation
    localparam int          LOW  = 3;
    localparam int          BASE = 4;
    localparam logic [11:0] CTRL = `WDT_CTRL_ADDR;
    localparam logic [11:0] STAT = `WDT_STAT_ADDR;
    localparam logic [11:0] MASK = `WDT_MASK_ADDR;

    logic        SYS_CLK, NRST;
    logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
    logic [3:0]  S_AXI_WSTRB;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
    logic        S_AXI_RVALID, S_AXI_RREADY;
    logic        WDT_SYS_RESET, WDT_NMI, IRQ;
    int          fails;
    int          cmp_count;

    keyed_watchdog_timer #(.EXP_LOW(LOW), .EXP_BASE(BASE)) dut (
        .SYS_CLK(SYS_CLK), .NRST(NRST),
        .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
        .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
        .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
        .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
        .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
        .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
        .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
        .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
        .S_AXI_RREADY(S_AXI_RREADY), .WDT_SYS_RESET(WDT_SYS_RESET),
        .WDT_NMI(WDT_NMI), .IRQ(IRQ)
    );

    always #2 SYS_CLK = ~SYS_CLK;

    task automatic final_report();
        $display("counts: %0d compared, %0d mismatched", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_rng(input string what, input int lo, hi, got);
        cmp_count++;
        if (got < lo || got > hi) begin
            fails++;
            $display("mismatch %s expected %0d..%0d seen %0d",
                     what, lo, hi, got);
        end
    endtask

    task automatic give_up(input string what);
        fails++;
        $display("mismatch %s expected an answer seen none", what);
        final_report();
    endtask

    // address and data offered together, each dropped once taken
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        bit got;
        got = 0;
        r = 2'h3;
        @(posedge SYS_CLK);
        S_AXI_AWADDR  <= a;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WDATA   <= d;
        S_AXI_WVALID  <= 1'b1;
        S_AXI_BREADY  <= 1'b1;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge SYS_CLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY)
                S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY)
                S_AXI_WVALID <= 1'b0;
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                r = S_AXI_BRESP;
                S_AXI_BREADY <= 1'b0;
                got = 1;
            end
        end
        if (!got) give_up("write response");
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        bit got;
        got = 0;
        @(posedge SYS_CLK);
        S_AXI_ARADDR  <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY  <= 1'b1;
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge SYS_CLK);
            if (S_AXI_ARVALID && S_AXI_ARREADY)
                S_AXI_ARVALID <= 1'b0;
            if (S_AXI_RVALID && S_AXI_RREADY) begin
                d = S_AXI_RDATA;
                r = S_AXI_RRESP;
                S_AXI_RREADY <= 1'b0;
                got = 1;
            end
        end
        if (!got) give_up("read data");
    endtask

    task automatic wreg(input logic [11:0] a, input logic [31:0] v);
        logic [1:0] r;
        axi_write(a, v, r);
    endtask

    task automatic wctl(input logic [15:0] v);
        wreg(CTRL, {16'h0000, v});
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
                        input string what);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        chk(what, exp, d);
    endtask

    task automatic unlock();
        wctl(`WDT_KEY_UNLOCK1);
        wctl(`WDT_KEY_UNLOCK2);
    endtask

    task automatic serve();
        wctl(`WDT_KEY_SERVE1);
        wctl(`WDT_KEY_SERVE2);
    endtask

    // n counts edges up to the pulse; the width check costs one more edge
    task automatic wait_pulse(input bit want_rst, input int lim,
                              output int n);
        for (n = 1; n <= lim; n++) begin
            @(posedge SYS_CLK);
            if (WDT_SYS_RESET === 1'b1 || WDT_NMI === 1'b1) begin
                chk("timeout kind", {30'h0, want_rst, !want_rst},
                    {30'h0, WDT_SYS_RESET, WDT_NMI});
                @(posedge SYS_CLK);
                chk("pulse width", 32'h0, {30'h0, WDT_SYS_RESET, WDT_NMI});
                return;
            end
        end
        give_up("timeout pulse");
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        rchk(CTRL, 32'h0000C080, "control after reset");
        rchk(STAT, 32'h0, "status after reset");
        rchk(MASK, 32'h0, "mask after reset");
        axi_read(12'h004, d, r);
        chk("unmapped read resp", `AXI_SLVERR, r);
        chk("unmapped read data", 32'h0, d);
        axi_write(12'h004, 32'h0000FFFF, r);
        chk("unmapped write resp", `AXI_SLVERR, r);
        wait_pulse(1, 1100, n);
        chk_rng("first timeout", 1024 - 60, 1024, n);
        rchk(CTRL, 32'h0000E080, "control after wdt reset");
        serve();
        rchk(CTRL, 32'h0000C080, "reset flag after key");
        $display("test reset done");
    endtask

    task automatic t_lock();
        int n;
        serve();
        wctl(16'h4000);
        rchk(CTRL, 32'h0000C080, "write while locked");
        unlock();
        wctl(16'h0F80);
        rchk(CTRL, 32'h00000080, "write after unlock");
        wctl(16'h8080);
        rchk(CTRL, 32'h00000080, "second write");
        wctl(`WDT_KEY_UNLOCK1);
        wctl(16'h1234);
        wctl(16'h8080);
        rchk(CTRL, 32'h00000080, "broken unlock");
        unlock();
        wctl(16'h4001);
        for (n = 0; n < 40; n++) begin
            @(posedge SYS_CLK);
            chk("disabled quiet", 32'h0,
                {30'h0, WDT_SYS_RESET, WDT_NMI});
        end
        $display("test lock done");
    endtask

    task automatic t_select();
        logic [7:0] sel [10] = '{8'h01, 8'hFF, 8'h02, 8'h06, 8'h04,
                                 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
        int         ex [10]  = '{LOW, LOW, BASE, BASE, BASE + 1, BASE + 2,
                                 BASE + 3, BASE + 4, BASE + 5, BASE + 6};
        int         n;
        for (int i = 0; i < 10; i++) begin
            serve();
            unlock();
            wctl({8'hC0, sel[i]});
            wait_pulse(1, (1 << ex[i]) + 20, n);
            chk_rng("timeout cycles", (1 << ex[i]) - 3,
                    (1 << ex[i]) + 2, n);
            unlock();
            wctl(16'h0080);
        end
        $display("test select done");
    endtask

    task automatic t_nmi();
        int n;
        wreg(STAT, 32'h3);
        serve();
        unlock();
        wctl(16'h8080);
        wait_pulse(0, 1100, n);
        rchk(CTRL, 32'h00009080, "nmi flag set");
        rchk(STAT, 32'h1, "nmi event status");
        chk("irq masked", 32'h0, {31'h0, IRQ});
        wreg(MASK, 32'h1);
        chk("irq unmasked", 32'h1, {31'h0, IRQ});
        wreg(STAT, 32'h1);
        chk("irq cleared", 32'h0, {31'h0, IRQ});
        serve();
        rchk(CTRL, 32'h00008080, "nmi flag after key");
        wait_pulse(0, 1100, n);
        chk_rng("nmi after service", 1000, 1024, n);
        wait_pulse(1, 1100, n);
        chk_rng("reset after nmi", 1023, 1023, n);
        rchk(CTRL, 32'h0000E080, "control after escalation");
        // the second interrupt event is still pending beside the reset one
        chk("irq second nmi", 32'h1, {31'h0, IRQ});
        wreg(STAT, 32'h1);
        chk("irq other bit masked", 32'h0, {31'h0, IRQ});
        wreg(MASK, 32'h3);
        chk("irq reset event", 32'h1, {31'h0, IRQ});
        wreg(STAT, 32'h3);
        chk("irq all cleared", 32'h0, {31'h0, IRQ});
        unlock();
        wctl(16'h0080);
        $display("test nmi done");
    endtask

    task automatic t_ext_reset();
        int n;
        serve();
        unlock();
        wctl(16'hC080);
        wait_pulse(1, 1100, n);
        rchk(CTRL, 32'h0000E080, "flag before pin reset");
        NRST <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        chk("outputs in reset", 32'h0,
            {29'h0, WDT_SYS_RESET, WDT_NMI, IRQ});
        NRST <= 1'b1;
        rchk(CTRL, 32'h0000C080, "flag after pin reset");
        rchk(STAT, 32'h0, "status after pin reset");
        rchk(MASK, 32'h0, "mask after pin reset");
        $display("test external reset done");
    endtask

    initial begin
        SYS_CLK       = 1'b0;
        NRST          = 1'b0;
        S_AXI_AWADDR  = 12'h000;
        S_AXI_AWVALID = 1'b0;
        S_AXI_WDATA   = 32'h0;
        S_AXI_WSTRB   = 4'hF;
        S_AXI_WVALID  = 1'b0;
        S_AXI_BREADY  = 1'b0;
        S_AXI_ARADDR  = 12'h000;
        S_AXI_ARVALID = 1'b0;
        S_AXI_RREADY  = 1'b0;
        fails         = 0;
        cmp_count     = 0;
        repeat (20) @(posedge SYS_CLK);
        NRST <= 1'b1;
        t_reset();
        t_lock();
        t_select();
        t_nmi();
        t_ext_reset();
        final_report();
    end
endmodule
